// [logic/dsf_dev.sv]
// Converter end: serial frame capture, register writes, reset entry
`timescale 1ns/1ps
`default_nettype none
`include "dsf_map.svh"
module dsf_dev (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        reset_pin_n,
    input  wire logic        internal_regulator_output_ok,
    input  wire logic        internal_analog_supply_node_ok,
    dsf_if.dev               link,
    output logic             in_reset,
    output logic             analog_output_terminal_en,
    output logic             pulldown_closed,
    output logic             crc_off,
    output logic             cal_refreshed,
    output logic             frame_taken,
    output logic [15:0]      dac_code,
    output logic [15:0]      out_level
);
    localparam dsf_pkg::dsf_dev_s DEV_RST = '{
        cs_m    : 1'b1,
        cs_s    : 1'b1,
        cs_p    : 1'b1,
        code    : `DSF_CODE_RST,
        default : '0
    };

    // Frame accepted for its bit count and checksum mode
    function automatic logic frame_ok(input logic [5:0] len,
                                      input logic       short_ok);
        frame_ok = (len == `DSF_LEN_LONG)
                 | (short_ok & (len == `DSF_LEN_SHORT));
    endfunction

    // Bring a short word up to the long layout
    function automatic logic [31:0] align(input logic [31:0] sh,
                                          input logic [5:0]  len);
        if (len == `DSF_LEN_LONG)
        begin
            align = sh;
        end
        else
        begin
            align = {sh[23:0], `DSF_CRC_FILL};
        end
    endfunction

    // Straight binary to offset level around midscale
    function automatic logic [15:0] to_bipolar(input logic [15:0] c);
        to_bipolar = {~c[`DSF_SIGN_BIT], c[14:0]};
    endfunction

    // Link side: bit count cleared while select is high
    logic [5:0]          cnt_q;
    logic [5:0]          cnt_nx;
    dsf_pkg::dsf_lnk_s   lk_q;
    dsf_pkg::dsf_lnk_s   lk_d;

    always_comb
    begin
        if (cnt_q == `DSF_LEN_OVER)
        begin
            cnt_nx = cnt_q;
        end
        else
        begin
            cnt_nx = cnt_q + `DSF_LEN_ONE;
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n)
    begin
        if (link.cs_n)
        begin
            cnt_q <= `DSF_LEN_ZERO;
        end
        else
        begin
            cnt_q <= cnt_nx;
        end
    end

    always_comb
    begin
        lk_d       = lk_q;
        lk_d.shift = {lk_q.shift[30:0], link.sdi};
        lk_d.len   = cnt_nx;
    end

    always_ff @(negedge link.sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lk_q <= '0;
        end
        else if (!link.cs_n)
        begin
            lk_q <= lk_d;
        end
    end

    // Local side
    dsf_pkg::dsf_dev_s   q;
    dsf_pkg::dsf_dev_s   d;
    logic                rst_now;
    logic                sel_end;
    logic [31:0]         w;

    always_comb
    begin
        d         = q;
        d.taken   = 1'b0;
        d.sw_rst  = 1'b0;
        d.pin_m   = {reset_pin_n, internal_regulator_output_ok,
                     internal_analog_supply_node_ok};
        d.pin_s   = q.pin_m;
        d.cs_m    = link.cs_n;
        d.cs_s    = q.cs_m;
        d.cs_p    = q.cs_s;
        rst_now   = ~(&q.pin_s) | q.sw_rst;
        sel_end   = q.cs_s & ~q.cs_p;
        w         = align(lk_q.shift, lk_q.len);
        if (rst_now)
        begin
            d.oe      = 1'b0;
            d.pd      = 1'b0;
            d.crc_off = 1'b0;
            d.cal_ok  = 1'b0;
            d.code    = `DSF_CODE_RST;
        end
        else if (sel_end & frame_ok(lk_q.len, q.crc_off))
        begin
            if (w[`DSF_DADDR_HI:`DSF_DADDR_LO] == `DSF_DEV_ADDR)
            begin
                d.taken = 1'b1;
                case (w[`DSF_RADDR_HI:`DSF_RADDR_LO])
                    `DSF_REG_DAC:
                    begin
                        d.code = w[`DSF_DATA_HI:`DSF_DATA_LO];
                    end
                    `DSF_REG_OUT:
                    begin
                        d.oe = w[`DSF_DATA_LO + `DSF_OE_BIT];
                    end
                    `DSF_REG_CONV2:
                    begin
                        d.pd = w[`DSF_DATA_LO + `DSF_PD_BIT];
                    end
                    `DSF_REG_IFACE:
                    begin
                        d.crc_off = w[`DSF_DATA_LO + `DSF_CRCOFF_BIT];
                    end
                    `DSF_REG_KEY:
                    begin
                        if (w[`DSF_DATA_HI:`DSF_DATA_LO] == `DSF_KEY_SWRST)
                        begin
                            d.sw_rst = 1'b1;
                        end
                        if (w[`DSF_DATA_HI:`DSF_DATA_LO] == `DSF_KEY_CALREF)
                        begin
                            d.cal_ok = 1'b1;
                        end
                    end
                    default:
                    begin
                        d.taken = 1'b0;
                    end
                endcase
            end
        end
        d.level = to_bipolar(d.code);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= DEV_RST;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // Reset also shows while pins or command hold it
    assign in_reset                  = ~(&q.pin_s) | q.sw_rst;
    assign analog_output_terminal_en = q.oe;
    assign pulldown_closed           = q.pd;
    assign crc_off                   = q.crc_off;
    assign cal_refreshed             = q.cal_ok;
    assign frame_taken               = q.taken;
    assign dac_code                  = q.code;
    assign out_level                 = q.level;
endmodule // dsf_dev
`default_nettype wire

// [pkg/dsf_map.svh]
// Constants of the serial frame and reset entry block
`ifndef DSF_MAP_SVH
`define DSF_MAP_SVH
`define DSF_LEN_ZERO   6'h00
`define DSF_LEN_ONE    6'h01
`define DSF_LEN_LONG   6'h20
`define DSF_LEN_SHORT  6'h18
`define DSF_LEN_OVER   6'h21
`define DSF_SLIP_BIT   31
`define DSF_DADDR_HI   30
`define DSF_DADDR_LO   29
`define DSF_RADDR_HI   28
`define DSF_RADDR_LO   24
`define DSF_DATA_HI    23
`define DSF_DATA_LO    8
`define DSF_CRC_HI     7
`define DSF_CRC_LO     0
`define DSF_CRC_FILL   8'h00
`define DSF_DEV_ADDR   2'h0
`define DSF_REG_DAC    5'h01
`define DSF_REG_OUT    5'h02
`define DSF_REG_CONV2  5'h03
`define DSF_REG_IFACE  5'h04
`define DSF_REG_KEY    5'h05
`define DSF_KEY_SWRST  16'hA5C3
`define DSF_KEY_CALREF 16'h3C5A
`define DSF_OE_BIT     0
`define DSF_PD_BIT     0
`define DSF_CRCOFF_BIT 0
`define DSF_CODE_RST   16'h0000
`define DSF_SIGN_BIT   15
`define DSF_CLK_MHZ    50
`define DSF_T_RST_US   100
`define DSF_T_CAL_US   500
`define DSF_GAP_CYC    15'h0004
`define DSF_WAIT_ZERO  15'h0000
`define DSF_WAIT_ONE   15'h0001
`define DSF_PH_ONE     2'h1
`define DSF_PH_RISE    2'h1
`define DSF_PH_FALL    2'h3
`endif

// [pkg/dsf_pkg.sv]
// Types of the serial frame and reset entry block
`default_nettype none
package dsf_pkg;
    typedef struct packed {
        logic [2:0]  pin_m;
        logic [2:0]  pin_s;
        logic        cs_m;
        logic        cs_s;
        logic        cs_p;
        logic        sw_rst;
        logic        oe;
        logic        pd;
        logic        crc_off;
        logic        cal_ok;
        logic        taken;
        logic [15:0] code;
        logic [15:0] level;
    } dsf_dev_s;

    typedef struct packed {
        logic [31:0] shift;
        logic [5:0]  len;
    } dsf_lnk_s;

    typedef enum logic [5:0] {
        H_BOOT  = 6'h01,
        H_CAL   = 6'h02,
        H_CALW  = 6'h04,
        H_IDLE  = 6'h08,
        H_SHIFT = 6'h10,
        H_END   = 6'h20
    } dsf_host_e;

    typedef struct packed {
        dsf_host_e   st;
        dsf_host_e   after;
        logic [1:0]  ph;
        logic [5:0]  bits;
        logic [5:0]  nbits;
        logic [31:0] sh;
        logic        sclk;
        logic        cs_n;
        logic        sdo;
        logic [14:0] wait_c;
    } dsf_host_s;
endpackage
`default_nettype wire

// [pkg/dsf_if.sv]
// Serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
interface dsf_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    modport dev  (input sclk, input cs_n, input sdi);
    modport host (output sclk, output cs_n, output sdi);
endinterface
`default_nettype wire

// [logic/dsf_host.sv]
// Host end: boot sequence, calibration refresh, frame shifting
`timescale 1ns/1ps
`default_nettype none
`include "dsf_map.svh"
module dsf_host #(
    parameter int RST_CYC = `DSF_T_RST_US * `DSF_CLK_MHZ,
    parameter int CAL_CYC = `DSF_T_CAL_US * `DSF_CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        req_valid,
    input  wire logic        req_short,
    input  wire logic [4:0]  req_addr,
    input  wire logic [15:0] req_data,
    input  wire logic [7:0]  req_crc,
    output logic             req_ready,
    dsf_if.host              link
);
    localparam dsf_pkg::dsf_host_s HOST_RST = '{
        st      : dsf_pkg::H_BOOT,
        after   : dsf_pkg::H_IDLE,
        cs_n    : 1'b1,
        default : '0
    };

    dsf_pkg::dsf_host_s q;
    dsf_pkg::dsf_host_s d;
    logic [31:0]        word;

    // Start a frame with its first bit already on the line
    function automatic dsf_pkg::dsf_host_s start(input dsf_pkg::dsf_host_s s,
                                                 input logic [31:0] wd,
                                                 input logic        sh24);
        start       = s;
        start.st    = dsf_pkg::H_SHIFT;
        start.cs_n  = 1'b0;
        start.sdo   = wd[`DSF_SLIP_BIT];
        start.sh    = {wd[30:0], 1'b0};
        start.ph    = '0;
        start.bits  = `DSF_LEN_ZERO;
        start.nbits = sh24 ? `DSF_LEN_SHORT : `DSF_LEN_LONG;
    endfunction

    always_comb
    begin
        d    = q;
        word = {1'b0, `DSF_DEV_ADDR, req_addr, req_data, req_crc};
        case (q.st)
            dsf_pkg::H_BOOT:
            begin
                d.wait_c = q.wait_c + `DSF_WAIT_ONE;
                if (q.wait_c == 15'(RST_CYC - 1))
                begin
                    d.st     = dsf_pkg::H_CAL;
                    d.wait_c = `DSF_WAIT_ZERO;
                end
            end
            dsf_pkg::H_CAL:
            begin
                d       = start(q, {1'b0, `DSF_DEV_ADDR, `DSF_REG_KEY,
                                    `DSF_KEY_CALREF, `DSF_CRC_FILL},
                                1'b0);
                d.after = dsf_pkg::H_CALW;
            end
            dsf_pkg::H_CALW:
            begin
                d.wait_c = q.wait_c + `DSF_WAIT_ONE;
                if (q.wait_c == 15'(CAL_CYC - 1))
                begin
                    d.st     = dsf_pkg::H_IDLE;
                    d.wait_c = `DSF_WAIT_ZERO;
                end
            end
            dsf_pkg::H_IDLE:
            begin
                if (req_valid)
                begin
                    d       = start(q, word, req_short);
                    d.after = dsf_pkg::H_IDLE;
                    if (req_addr == `DSF_REG_KEY)
                    begin
                        if (req_data == `DSF_KEY_SWRST)
                        begin
                            d.after = dsf_pkg::H_BOOT;
                        end
                        if (req_data == `DSF_KEY_CALREF)
                        begin
                            d.after = dsf_pkg::H_CALW;
                        end
                    end
                end
            end
            dsf_pkg::H_SHIFT:
            begin
                d.ph = q.ph + `DSF_PH_ONE;
                if (q.ph == `DSF_PH_RISE)
                begin
                    d.sclk = 1'b1;
                    if (q.bits != `DSF_LEN_ZERO)
                    begin
                        d.sdo = q.sh[31];
                        d.sh  = {q.sh[30:0], 1'b0};
                    end
                end
                if (q.ph == `DSF_PH_FALL)
                begin
                    d.sclk = 1'b0;
                    d.bits = q.bits + `DSF_LEN_ONE;
                    if (q.bits + `DSF_LEN_ONE == q.nbits)
                    begin
                        d.st = dsf_pkg::H_END;
                    end
                end
            end
            dsf_pkg::H_END:
            begin
                d.cs_n   = 1'b1;
                d.sdo    = 1'b0;
                d.wait_c = q.wait_c + `DSF_WAIT_ONE;
                if (q.wait_c == `DSF_GAP_CYC)
                begin
                    d.st     = q.after;
                    d.wait_c = `DSF_WAIT_ZERO;
                end
            end
            default:
            begin
                d = HOST_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= HOST_RST;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign req_ready = ce & (q.st == dsf_pkg::H_IDLE);
    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.sdi  = q.sdo;
endmodule // dsf_host
`default_nettype wire

// [bench/dsf_link_asserts.sv]
// Checker on the serial link and the converter end
`timescale 1ns/1ps
`default_nettype none
module dsf_link_asserts #(
    parameter int RST_CYC = 20
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        sdi,
    input wire logic        reset_pin_n,
    input wire logic        internal_regulator_output_ok,
    input wire logic        in_reset,
    input wire logic        analog_output_terminal_en,
    input wire logic        pulldown_closed,
    input wire logic        frame_taken,
    input wire logic [15:0] dac_code,
    input wire logic [15:0] out_level
);
    logic        sclk_q;
    logic [5:0]  falls_q;
    logic [15:0] age_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_q  <= 1'b0;
            falls_q <= 6'h00;
            age_q   <= 16'h0000;
        end
        else
        begin
            sclk_q  <= sclk;
            falls_q <= cs_n ? 6'h00 : falls_q + 6'(sclk_q & ~sclk);
            age_q   <= (age_q == 16'hFFFF) ? age_q : age_q + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_select_high;
        cs_n [*4];
    endsequence
    sequence s_one_pulse;
        frame_taken ##1 !frame_taken;
    endsequence
    property p_sclk_idle;
        cs_n |-> !sclk;
    endproperty
    property p_frame_len;
        $rose(cs_n) |-> falls_q == 6'h20 || falls_q == 6'h18;
    endproperty
    property p_sdi_hold;
        sclk_q && !sclk && !cs_n |-> $stable(sdi);
    endproperty
    property p_gap;
        $rose(cs_n) |-> s_select_high;
    endproperty
    property p_quiet;
        !cs_n |-> age_q >= 16'(RST_CYC);
    endproperty
    property p_bipolar;
        $changed(dac_code) && dac_code != 16'h0000 && !in_reset |->
            ##[0:2] out_level == {~dac_code[15], dac_code[14:0]};
    endproperty
    property p_defaults;
        in_reset [*2] |-> !analog_output_terminal_en && !pulldown_closed
            && dac_code == 16'h0000;
    endproperty
    property p_pin;
        !reset_pin_n [*5] |-> in_reset;
    endproperty
    property p_supply;
        !internal_regulator_output_ok [*5] |-> in_reset;
    endproperty
    property p_taken;
        frame_taken |-> ($past(cs_n, 3) && $past(cs_n, 2) && cs_n)
            ##0 s_one_pulse;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("link clock not idle low");
    a_frame_len: assert property (p_frame_len)
        else $error("frame bit count wrong");
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("data moved at capture edge");
    a_gap: assert property (p_gap)
        else $error("select gap too short");
    a_quiet: assert property (p_quiet)
        else $error("frame too soon after reset");
    a_bipolar: assert property (p_bipolar)
        else $error("output level does not match code");
    a_defaults: assert property (p_defaults)
        else $error("defaults not held in reset");
    a_pin: assert property (p_pin)
        else $error("reset pin ignored");
    a_supply: assert property (p_supply)
        else $error("low supply ignored");
    a_taken: assert property (p_taken)
        else $error("frame taken before select rose");
endmodule // dsf_link_asserts
`default_nettype wire

// [bench/dac_serial_frame_and_reset_entry_tb.sv]
// Testbench: host and converter ends joined, plus a fault link
`timescale 1ns/1ps
`default_nettype none
`include "dsf_map.svh"
module dac_serial_frame_and_reset_entry_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        pin_n = 1'b1;
    logic        reg_ok = 1'b1;
    logic        ana_ok = 1'b1;
    logic        rq_v = 1'b0;
    logic        rq_s = 1'b0;
    logic [4:0]  rq_a = 5'h00;
    logic [15:0] rq_d = 16'h0000;
    logic        rdy;
    logic        rst, en, pd, crc, cal, tk;
    logic [15:0] code, lvl, x_code;
    logic [15:0] codes [4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h0001};
    int          mismatches = 0;
    int          checks_done = 0;
    int          taken_n = 0;
    int          gap_n = 0;
    int          last_gap = 0;
    dsf_if lnk ();
    dsf_if lnk2 ();
    always #10 clk = ~clk;
    // Frame pulses and select-high wait before ready returns
    always @(posedge clk)
    begin
        if (tk === 1'b1)
            taken_n <= taken_n + 1;
        gap_n <= (lnk.cs_n === 1'b1 && rdy !== 1'b1) ? gap_n + 1 : 0;
        if (rdy === 1'b1 && gap_n != 0)
            last_gap <= gap_n;
    end
    dsf_host #(.RST_CYC(20), .CAL_CYC(40)) dsf_host_i (
        .clk(clk), .rstn(rstn), .ce(ce), .req_valid(rq_v),
        .req_short(rq_s), .req_addr(rq_a), .req_data(rq_d),
        .req_crc(8'hFF), .req_ready(rdy), .link(lnk));
    dsf_dev dsf_dev_i (
        .clk(clk), .rstn(rstn), .ce(ce), .reset_pin_n(pin_n),
        .internal_regulator_output_ok(reg_ok),
        .internal_analog_supply_node_ok(ana_ok), .link(lnk),
        .in_reset(rst), .analog_output_terminal_en(en),
        .pulldown_closed(pd), .crc_off(crc), .cal_refreshed(cal),
        .frame_taken(tk), .dac_code(code), .out_level(lvl));
    dsf_dev dsf_dev_x_i (
        .clk(clk), .rstn(rstn), .ce(ce), .reset_pin_n(pin_n),
        .internal_regulator_output_ok(reg_ok),
        .internal_analog_supply_node_ok(ana_ok), .link(lnk2),
        .in_reset(), .analog_output_terminal_en(), .pulldown_closed(),
        .crc_off(), .cal_refreshed(), .frame_taken(),
        .dac_code(x_code), .out_level());
    dsf_link_asserts #(.RST_CYC(20)) dsf_link_asserts_i (
        .clk(clk), .rstn(rstn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
        .sdi(lnk.sdi), .reset_pin_n(pin_n),
        .internal_regulator_output_ok(reg_ok), .in_reset(rst),
        .analog_output_terminal_en(en), .pulldown_closed(pd),
        .frame_taken(tk), .dac_code(code), .out_level(lvl));
    task automatic check_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic check_word(input string n, input logic [15:0] e,
                              input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_ready;
        for (int k = 0; k < 600; k++)
        begin
            @(negedge clk);
            if (rdy === 1'b1)
                break;
        end
        if (rdy !== 1'b1)
        begin
            check_bit("req_ready", 1'b1, rdy);
            wrap_up();
        end
    endtask
    // Host write through the user port, then let the device settle
    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic s);
        wait_ready();
        @(posedge clk);
        rq_v <= 1'b1;
        rq_a <= a;
        rq_d <= d;
        rq_s <= s;
        @(posedge clk);
        rq_v <= 1'b0;
        wait_ready();
        repeat (8) @(posedge clk);
    endtask
    // Raw frame on the fault link; data moves after each falling edge
    task automatic raw(input logic [1:0] dv, input logic [15:0] d,
                       input int n, input logic [15:0] e);
        logic [31:0] w;
        w = {1'b0, dv, `DSF_REG_DAC, d, 8'hFF};
        lnk2.cs_n <= 1'b0;
        #8;
        for (int i = 31; i > 31 - n; i--)
        begin
            lnk2.sclk <= 1'b1;
            #2 lnk2.sdi <= w[i];
            #5.5 lnk2.sclk <= 1'b0;
            #2 lnk2.sdi <= ~w[i];
            #5.5;
        end
        lnk2.cs_n <= 1'b1;
        repeat (12) @(posedge clk);
        check_word("fault link dac_code", e, x_code);
    endtask
    initial
    begin
        lnk2.cs_n = 1'b1;
        lnk2.sclk = 1'b0;
        lnk2.sdi = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        wait_ready();
        check_bit("cal_refreshed", 1'b1, cal);
        check_bit("in_reset", 1'b0, rst);
        check_bit("output enable", 1'b0, en);
        check_bit("pull-down", 1'b0, pd);
        check_bit("crc_off", 1'b0, crc);
        foreach (codes[i])
        begin
            wr(`DSF_REG_DAC, codes[i], 1'b0);
            check_word("dac_code", codes[i], code);
            check_word("out_level", codes[i] ^ 16'h8000, lvl);
        end
        wr(5'h1F, 16'h1234, 1'b0);
        check_word("dac_code", 16'h0001, code);
        check_word("frames taken", 16'h0005, 16'(taken_n));
        wr(`DSF_REG_OUT, 16'h0001, 1'b0);
        check_bit("output enable", 1'b1, en);
        wr(`DSF_REG_CONV2, 16'h0001, 1'b0);
        check_bit("pull-down", 1'b1, pd);
        wr(`DSF_REG_IFACE, 16'h0001, 1'b0);
        check_bit("crc_off", 1'b1, crc);
        wr(`DSF_REG_DAC, 16'h1234, 1'b1);
        check_word("dac_code", 16'h1234, code);
        wr(`DSF_REG_DAC, 16'hABCD, 1'b0);
        check_word("dac_code", 16'hABCD, code);
        wr(`DSF_REG_KEY, `DSF_KEY_SWRST, 1'b0);
        check_bit("output enable", 1'b0, en);
        check_bit("pull-down", 1'b0, pd);
        check_bit("crc_off", 1'b0, crc);
        check_bit("cal_refreshed", 1'b1, cal);
        check_word("dac_code", 16'h0000, code);
        wr(`DSF_REG_KEY, `DSF_KEY_CALREF, 1'b0);
        check_bit("cal_refreshed", 1'b1, cal);
        check_bit("refresh wait", 1'b1, last_gap >= 40);
        raw(2'h0, 16'h5A5A, 32, 16'h5A5A);
        raw(2'h1, 16'h1111, 32, 16'h5A5A);
        raw(2'h0, 16'h2222, 31, 16'h5A5A);
        raw(2'h0, 16'h3333, 24, 16'h5A5A);
        wr(`DSF_REG_OUT, 16'h0001, 1'b0);
        wr(`DSF_REG_DAC, 16'h0F0F, 1'b0);
        ce <= 1'b0;
        pin_n <= 1'b0;
        repeat (3) @(posedge clk);
        check_bit("req_ready", 1'b0, rdy);
        pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        check_bit("in_reset", 1'b0, rst);
        check_bit("output enable", 1'b1, en);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        check_bit("in_reset", 1'b1, rst);
        check_bit("cal_refreshed", 1'b0, cal);
        check_bit("output enable", 1'b0, en);
        check_word("dac_code", 16'h0000, code);
        wr(`DSF_REG_DAC, 16'h4321, 1'b0);
        pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_bit("in_reset", 1'b0, rst);
        check_word("dac_code", 16'h0000, code);
        reg_ok <= 1'b0;
        repeat (6) @(posedge clk);
        check_bit("in_reset", 1'b1, rst);
        reg_ok <= 1'b1;
        ana_ok <= 1'b0;
        repeat (6) @(posedge clk);
        check_bit("in_reset", 1'b1, rst);
        ana_ok <= 1'b1;
        repeat (6) @(posedge clk);
        check_bit("in_reset", 1'b0, rst);
        wrap_up();
    end
endmodule // dac_serial_frame_and_reset_entry_tb
`default_nettype wire
